/* pcr_regs.v */
`include "pcr_defs.vh"
module pcr_regs #(
	parameter CLK_HZ = `PCR_CLK_HZ
) (
	// clock and resets
	input wire clk_i,
	input wire rst_n_i,
	input wire sys_rst_n_i,
	input wire ce_i,
	// register port
	input wire wr_i,
	input wire rd_i,
	input wire [7:0] addr_i,
	input wire [7:0] wdata_i,
	output reg [7:0] rdata_o,
	// board and pins
	input wire usb_present_i,
	input wire inputs_tied_i,
	input wire power_key_n_i,
	// events
	input wire [31:0] evt_i,
	// controls
	output wire [3:0] usb_limit_o,
	output wire temp_loop_en_o,
	output wire [7:0] charge_low_temp_threshold_o,
	output wire [7:0] charge_high_temp_threshold_o,
	output wire [7:0] work_low_temp_threshold_o,
	output wire [7:0] work_high_temp_threshold_o,
	output wire ac_input_connect_o,
	output wire [2:0] input_hold_voltage_o,
	output wire [3:0] ac_input_limit_o,
	output wire spread_en_o,
	output wire spread_wide_o,
	output wire power_save_operation_o,
	output wire [3:0] osc_code_o,
	output wire [2:0] off_activity_o,
	output wire reduced_serial_bus_o,
	output reg shutdown_o,
	output wire auto_on_o,
	output wire irq_o
);
	reg [7:0] usb_reg, key_reg, offt_reg, clt_reg, cht_reg, ac_reg;
	reg [7:0] frq_reg, wlt_reg, wht_reg, ifm_reg;
	reg [7:0] ie1_reg, ie2_reg, ie3_reg, ie4_reg;
	reg usb_d_reg;
	reg [35:0] hold_reg;
	wire usb_s, key_s;
	wire [31:0] flags;
	wire [3:0] pend;
	wire [31:0] clr;
	wire [31:0] en;
	genvar g;

	// widened on purpose so the product below cannot wrap
	localparam [35:0] SEC = 36'd1 * CLK_HZ;

	////////////////////////////////////////////////////////////////
	pcr_sync u_usb (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
		.d_i(usb_present_i), .q_o(usb_s));
	pcr_sync u_key (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
		.d_i(~power_key_n_i), .q_o(key_s));

	////////////////////////////////////////////////////////////////
	// power-on reset fields
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			usb_reg <= `PCR_R_USB;
			key_reg <= `PCR_R_KEY;
			offt_reg <= `PCR_R_OFFT;
			clt_reg <= `PCR_R_CLT;
			cht_reg <= `PCR_R_CHT;
			ac_reg <= `PCR_R_AC;
			frq_reg <= `PCR_R_FRQ;
			wlt_reg <= `PCR_R_WLT;
			wht_reg <= `PCR_R_WHT;
			ifm_reg <= `PCR_R_IFM;
			ie1_reg <= `PCR_R_IE1;
			ie2_reg <= `PCR_R_IE2;
			ie3_reg <= `PCR_R_IE3;
			ie4_reg <= `PCR_R_IE4;
			usb_d_reg <= 1'b0;
		end
		else if (ce_i)
		begin
			usb_d_reg <= usb_s;
			if (!sys_rst_n_i)
			begin
				key_reg[`PCR_B_OFFEN] <= 1'b1;
				ac_reg[`PCR_B_ACCON] <= 1'b1;
			end
			else if (wr_i)
			begin
				case (addr_i)
					`PCR_A_USB: usb_reg <= wdata_i & `PCR_M_USB;
					`PCR_A_KEY: key_reg <= wdata_i;
					`PCR_A_OFFT: offt_reg <= wdata_i & `PCR_M_OFFT;
					`PCR_A_CLT: clt_reg <= wdata_i;
					`PCR_A_CHT: cht_reg <= wdata_i;
					`PCR_A_AC: ac_reg <= wdata_i & `PCR_M_AC;
					`PCR_A_FRQ: frq_reg <= wdata_i & `PCR_M_FRQ;
					`PCR_A_WLT: wlt_reg <= wdata_i;
					`PCR_A_WHT: wht_reg <= wdata_i;
					`PCR_A_IFM: ifm_reg <= wdata_i;
					`PCR_A_IE1: ie1_reg <= wdata_i & `PCR_M_IE1;
					`PCR_A_IE2: ie2_reg <= wdata_i & `PCR_M_IE2;
					`PCR_A_IE3: ie3_reg <= wdata_i;
					`PCR_A_IE4: ie4_reg <= wdata_i & `PCR_M_IE4;
					default: ;
				endcase
			end
			// usb unplug wins over a write in the same cycle
			if (usb_d_reg && !usb_s)
				usb_reg[7:4] <= `PCR_R_USBLIM;
		end
	end

	////////////////////////////////////////////////////////////////
	// key hold timer, off time 4/6/8/10 s
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			hold_reg <= 36'h0;
			shutdown_o <= 1'b0;
		end
		else if (ce_i)
		begin
			if (!key_s)
				hold_reg <= 36'h0;
			else if (!shutdown_o)
				hold_reg <= hold_reg + 36'h1;
			if (key_s && key_reg[`PCR_B_OFFEN] && hold_reg >=
				SEC * (`PCR_OFF_BASE_S + `PCR_OFF_STEP_S * key_reg[1:0]))
				shutdown_o <= 1'b1;
			else if (!key_s)
				shutdown_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// status flags, write one to clear
	assign en = {ie4_reg, ie3_reg, ie2_reg, ie1_reg};
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : g_st
			assign clr[g*8+7:g*8] = (wr_i && sys_rst_n_i &&
				addr_i == `PCR_A_IS1 + g) ? wdata_i : 8'h00;
			pcr_stat u_st (.clk_i(clk_i), .rst_n_i(rst_n_i),
				.ce_i(ce_i), .evt_i(evt_i[g*8+7:g*8] & en[g*8+7:g*8]),
				.clr_i(clr[g*8+7:g*8]), .en_i(en[g*8+7:g*8]),
				.flag_o(flags[g*8+7:g*8]), .pend_o(pend[g]));
		end
	endgenerate
	assign irq_o = |pend;

	////////////////////////////////////////////////////////////////
	always @*
	begin
		case (addr_i)
			`PCR_A_USB: rdata_o = usb_reg;
			`PCR_A_KEY: rdata_o = key_reg;
			`PCR_A_OFFT: rdata_o = offt_reg;
			`PCR_A_CLT: rdata_o = clt_reg;
			`PCR_A_CHT: rdata_o = cht_reg;
			`PCR_A_AC: rdata_o = ac_reg;
			`PCR_A_FRQ: rdata_o = frq_reg;
			`PCR_A_WLT: rdata_o = wlt_reg;
			`PCR_A_WHT: rdata_o = wht_reg;
			`PCR_A_IFM: rdata_o = ifm_reg;
			`PCR_A_IE1: rdata_o = ie1_reg;
			`PCR_A_IE2: rdata_o = ie2_reg;
			`PCR_A_IE3: rdata_o = ie3_reg;
			`PCR_A_IE4: rdata_o = ie4_reg;
			`PCR_A_IS1: rdata_o = flags[7:0];
			`PCR_A_IS2: rdata_o = flags[15:8];
			`PCR_A_IS3: rdata_o = flags[23:16];
			`PCR_A_IS4: rdata_o = flags[31:24];
			default: rdata_o = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////
	assign usb_limit_o = usb_reg[7:4];
	assign temp_loop_en_o = usb_reg[`PCR_B_TLOOP];
	assign auto_on_o = key_reg[`PCR_B_AUTOON];
	assign off_activity_o = offt_reg[2:0];
	assign charge_low_temp_threshold_o = clt_reg;
	assign charge_high_temp_threshold_o = cht_reg;
	assign work_low_temp_threshold_o = wlt_reg;
	assign work_high_temp_threshold_o = wht_reg;
	assign ac_input_connect_o = ac_reg[`PCR_B_ACCON];
	assign input_hold_voltage_o = ac_reg[5:3];
	// ac codes passed as 0..7 widened; tied inputs take usb code
	assign ac_input_limit_o = inputs_tied_i ? usb_reg[7:4] :
		{1'b0, ac_reg[2:0]};
	assign spread_en_o = frq_reg[`PCR_B_SPREN];
	assign spread_wide_o = frq_reg[`PCR_B_SPRNG];
	assign power_save_operation_o = frq_reg[`PCR_B_AUTOM];
	assign osc_code_o = frq_reg[3:0];
	assign reduced_serial_bus_o = (ifm_reg == `PCR_RSB_CODE);
endmodule // pcr_regs

/* pcr_defs.vh */
`ifndef PCR_DEFS_VH
`define PCR_DEFS_VH
// Overview of operation
// - usb limit bits 7:4, default 0001
// - usb limit restored on usb falling edge
// - bit 3 enables charger temperature loop
// - key held past off time shuts down
// - bit 2 selects auto power-on after shutdown
// - shutdown enable and ac connect bit restored by system reset
// - power-off activity time, 3 bits, 10s steps
// - charge temperature thresholds, defaults A5H, 1FH
// - work temperature thresholds, defaults FCH, 16H
// - ac path connect bit, system reset
// - ac hold voltage bits 5:3
// - ac current limit bits 2:0
// - tied inputs use usb current limit
// - frequency spread enable and range
// - mode bit selects pwm or auto
// - oscillator code bits 3:0, default 1000
// - 7CH selects reduced serial bus
// - input event enables, default D8H
// - battery event enables, default FCH
// - battery temperature enables, default FFH
// - misc enables, default 03H
// - status flag cleared by writing one

// register offsets
`define PCR_A_USB 8'h35
`define PCR_A_KEY 8'h36
`define PCR_A_OFFT 8'h37
`define PCR_A_CLT 8'h38
`define PCR_A_CHT 8'h39
`define PCR_A_AC 8'h3A
`define PCR_A_FRQ 8'h3B
`define PCR_A_WLT 8'h3C
`define PCR_A_WHT 8'h3D
`define PCR_A_IFM 8'h3E
`define PCR_A_IE1 8'h40
`define PCR_A_IE2 8'h41
`define PCR_A_IE3 8'h42
`define PCR_A_IE4 8'h43
`define PCR_A_IS1 8'h48
`define PCR_A_IS2 8'h49
`define PCR_A_IS3 8'h4A
`define PCR_A_IS4 8'h4B

// reset values
`define PCR_R_USB 8'h18
`define PCR_R_KEY 8'h59
`define PCR_R_OFFT 8'h00
`define PCR_R_CLT 8'hA5
`define PCR_R_CHT 8'h1F
`define PCR_R_AC 8'h80
`define PCR_R_FRQ 8'h08
`define PCR_R_WLT 8'hFC
`define PCR_R_WHT 8'h16
`define PCR_R_IFM 8'h00
`define PCR_R_IE1 8'hD8
`define PCR_R_IE2 8'hFC
`define PCR_R_IE3 8'hFF
`define PCR_R_IE4 8'h03
`define PCR_R_USBLIM 4'h1

// writable masks (reserved bits read zero)
`define PCR_M_USB 8'hF8
`define PCR_M_OFFT 8'h07
`define PCR_M_AC 8'hBF
`define PCR_M_FRQ 8'hDF
`define PCR_M_IE1 8'hFC
`define PCR_M_IE2 8'hFC
`define PCR_M_IE4 8'h87

// field positions and codes
`define PCR_B_TLOOP 3
`define PCR_B_OFFEN 3
`define PCR_B_AUTOON 2
`define PCR_B_ACCON 7
`define PCR_B_SPREN 7
`define PCR_B_SPRNG 6
`define PCR_B_AUTOM 4
`define PCR_RSB_CODE 8'h7C

// timing
`define PCR_CLK_HZ 250000000
`define PCR_OFF_BASE_S 4
`define PCR_OFF_STEP_S 2
`endif

/* pcr_sync.v */
module pcr_sync (
	// clock
	input wire clk_i,
	input wire rst_n_i,
	input wire ce_i,
	// data
	input wire d_i,
	output wire q_o
);
	reg s1_reg;
	reg s2_reg;
	reg s3_reg;
	reg q_reg;

	// stage one feeds stage two only
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			q_reg <= 1'b0;
		end
		else if (ce_i)
		begin
			s1_reg <= d_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg)
				q_reg <= s3_reg;
		end
	end
	assign q_o = q_reg;
endmodule // pcr_sync

/* pcr_stat.v */
`include "pcr_defs.vh"
module pcr_stat (
	// clock
	input wire clk_i,
	input wire rst_n_i,
	input wire ce_i,
	// events and clears
	input wire [7:0] evt_i,
	input wire [7:0] clr_i,
	input wire [7:0] en_i,
	// state
	output wire [7:0] flag_o,
	output wire pend_o
);
	reg [7:0] flag_reg;

	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			flag_reg <= 8'h00;
		else if (ce_i)
			flag_reg <= evt_i | (flag_reg & ~clr_i);
	end
	assign flag_o = flag_reg;
	assign pend_o = |(flag_reg & en_i);
endmodule // pcr_stat

/* pcr_regs_monitor.sv */
module pcr_regs_monitor #(
	parameter CLK_HZ = 10
) (
	// clock, resets, register port
	input wire clk_i, rst_n_i, sys_rst_n_i, ce_i, wr_i,
	input wire [7:0] addr_i, wdata_i, rdata_o,
	// board
	input wire usb_present_i, inputs_tied_i,
	input wire [31:0] evt_i,
	// controls
	input wire [3:0] usb_limit_o, ac_input_limit_o, osc_code_o,
	input wire [2:0] off_activity_o,
	input wire temp_loop_en_o, ac_input_connect_o, spread_en_o,
	input wire spread_wide_o, power_save_operation_o,
	input wire reduced_serial_bus_o, irq_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////////////////////////////
	// a usb drop racing a write is not covered here
	a_usb_write: assert property ((ce_i && wr_i && sys_rst_n_i &&
		addr_i == 8'h35 && usb_present_i) |=>
		{usb_limit_o, 4'h0} == ($past(wdata_i) & 8'hF0))
		else $error("usb limit not taken from write");
	a_usb_drop: assert property ($fell(usb_present_i) |->
		##[1:8] usb_limit_o == 4'h1)
		else $error("usb limit not restored on usb drop");
	a_temp_loop: assert property ((addr_i == 8'h35) |->
		rdata_o[3] == temp_loop_en_o && rdata_o[2:0] == 3'h0)
		else $error("temperature loop bit mismatch");
	a_off_time: assert property ((addr_i == 8'h37) |->
		rdata_o[7:3] == 5'h00 && rdata_o[2:0] == off_activity_o)
		else $error("off activity field mismatch");
	a_sys_conn: assert property (!sys_rst_n_i |=>
		ac_input_connect_o)
		else $error("ac path not restored by system reset");
	a_tied_limit: assert property (inputs_tied_i |->
		ac_input_limit_o == usb_limit_o)
		else $error("tied inputs not using usb limit");
	a_freq_map: assert property ((addr_i == 8'h3B) |->
		{spread_en_o, spread_wide_o, power_save_operation_o,
		osc_code_o} == {rdata_o[7:6], rdata_o[4:0]})
		else $error("frequency controls mismatch");
	a_rsb_mode: assert property ((addr_i == 8'h3E) |->
		reduced_serial_bus_o == (rdata_o == 8'h7C))
		else $error("interface mode mismatch");
	a_irq_quiet: assert property ((ce_i && !wr_i &&
		evt_i == 32'h0 && !irq_o) |=> !irq_o)
		else $error("interrupt rose without event");
endmodule // pcr_regs_monitor

/* pcr_host.sv */
module pcr_host (
	// clock
	input wire clk_i,
	// register port
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	input wire [7:0] rdata_i
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {wr_o, rd_o, addr_o, wdata_o} = 18'h0;
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#1;
		wr_o = 1'b1;
		addr_o = a;
		wdata_o = d;
		@(posedge clk_i);
		#1;
		wr_o = 1'b0;
		// idle data shows no stale value
		wdata_o = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		#1;
		rd_o = 1'b1;
		addr_o = a;
		#2;
		d = rdata_i;
		@(posedge clk_i);
		#1;
		rd_o = 1'b0;
	endtask
endmodule // pcr_host

/* test_pcr_regs.sv */
module test_pcr_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, rst_n_i = 0, sys_rst_n_i = 1, usb_present_i = 1;
	logic inputs_tied_i = 0, power_key_n_i = 1;
	logic [31:0] evt_i = 32'h0;
	logic wr_i, rd_i, shutdown_o, auto_on_o, irq_o, reduced_serial_bus;
	logic [7:0] addr_i, wdata_i, rdata_o, v;
	logic [3:0] usb_limit_o, ac_lim;
	int num_errors = 0, checks = 0, cyc = 0;
	// addr, reset value, writable mask; 3F is unmapped
	logic [23:0] rows [15] = '{24'h3518F8, 24'h3659FF, 24'h370007,
		24'h38A5FF, 24'h391FFF, 24'h3A80BF, 24'h3B08DF, 24'h3CFCFF,
		24'h3D16FF, 24'h3E00FF, 24'h40D8FC, 24'h41FCFC, 24'h42FFFF,
		24'h430387, 24'h3F0000};
	always #2 clk_i = ~clk_i;
	pcr_host h (.clk_i(clk_i), .wr_o(wr_i), .rd_o(rd_i),
		.addr_o(addr_i), .wdata_o(wdata_i), .rdata_i(rdata_o));
	pcr_regs #(.CLK_HZ(10)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.sys_rst_n_i(sys_rst_n_i), .ce_i(1'b1), .wr_i(wr_i),
		.rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.rdata_o(rdata_o), .usb_present_i(usb_present_i),
		.inputs_tied_i(inputs_tied_i), .power_key_n_i(power_key_n_i),
		.evt_i(evt_i), .usb_limit_o(usb_limit_o), .temp_loop_en_o(),
		.charge_low_temp_threshold_o(), .charge_high_temp_threshold_o(),
		.work_low_temp_threshold_o(), .work_high_temp_threshold_o(),
		.ac_input_connect_o(), .input_hold_voltage_o(),
		.ac_input_limit_o(ac_lim), .spread_en_o(), .spread_wide_o(),
		.power_save_operation_o(), .osc_code_o(), .off_activity_o(),
		.reduced_serial_bus_o(reduced_serial_bus), .shutdown_o(shutdown_o),
		.auto_on_o(auto_on_o), .irq_o(irq_o));
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e)
		begin
			num_errors++;
			$display("Error value exp %h got %h", e, s);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		h.rd(a, v);
		check(v, e);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic pulse(input logic [7:0] en);
		h.wr(8'h40, en);
		tick(1);
		evt_i[7] = 1'b1;
		tick(1);
		evt_i = 32'h0;
	endtask
	task automatic close_out;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ceiling well above the few hundred cycles used
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			close_out;
		end
	end
	////////////////////////////////////////////////////////////////
	initial
	begin
		tick(20);
		rst_n_i = 1'b1;
		foreach (rows[i])
		begin
			rchk(rows[i][23:16], rows[i][15:8]);
			h.wr(rows[i][23:16], 8'hFF);
			rchk(rows[i][23:16], rows[i][7:0]);
		end
		check(usb_limit_o, 8'h0F);
		check(ac_lim, 8'h07);
		check(reduced_serial_bus, 8'h00);
		usb_present_i = 1'b0;
		tick(8);
		rchk(8'h35, 8'h18);
		usb_present_i = 1'b1;
		inputs_tied_i = 1'b1;
		tick(1);
		check(ac_lim, 8'h01);
		inputs_tied_i = 1'b0;
		h.wr(8'h36, 8'h00);
		h.wr(8'h3A, 8'h00);
		sys_rst_n_i = 1'b0;
		tick(1);
		sys_rst_n_i = 1'b1;
		rchk(8'h36, 8'h08);
		rchk(8'h3A, 8'h80);
		power_key_n_i = 1'b0;
		tick(30);
		check(shutdown_o, 8'h00);
		for (int i = 0; i < 40 && shutdown_o !== 1'b1; i++)
			tick(1);
		check(shutdown_o, 8'h01);
		power_key_n_i = 1'b1;
		tick(10);
		check(shutdown_o, 8'h00);
		h.wr(8'h36, 8'h04);
		power_key_n_i = 1'b0;
		tick(60);
		check(shutdown_o, 8'h00);
		check(auto_on_o, 8'h01);
		power_key_n_i = 1'b1;
		pulse(8'h00);
		check(irq_o, 8'h00);
		pulse(8'h80);
		check(irq_o, 8'h01);
		h.wr(8'h48, 8'h80);
		check(irq_o, 8'h00);
		h.wr(8'h3E, 8'h7C);
		check(reduced_serial_bus, 8'h01);
		h.wr(8'h3E, 8'h7D);
		check(reduced_serial_bus, 8'h00);
		close_out;
	end
endmodule // test_pcr_regs

bind pcr_regs pcr_regs_monitor #(.CLK_HZ(CLK_HZ)) mon (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .sys_rst_n_i(sys_rst_n_i),
	.ce_i(ce_i), .wr_i(wr_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.rdata_o(rdata_o), .usb_present_i(usb_present_i),
	.inputs_tied_i(inputs_tied_i), .evt_i(evt_i),
	.usb_limit_o(usb_limit_o), .ac_input_limit_o(ac_input_limit_o),
	.osc_code_o(osc_code_o), .off_activity_o(off_activity_o),
	.temp_loop_en_o(temp_loop_en_o),
	.ac_input_connect_o(ac_input_connect_o), .spread_en_o(spread_en_o),
	.spread_wide_o(spread_wide_o),
	.power_save_operation_o(power_save_operation_o),
	.reduced_serial_bus_o(reduced_serial_bus_o), .irq_o(irq_o));
